//--- sfc_host.v
// Purpose: host controller driving a serial flash over its SPI pins
// Assumes: mode 0 framing, sck made here from a divider of clock
// Notes:   read data stalls sck while the receive buffer is full
`timescale 1ns/1ps
`include "sfc_consts.vh"
module sfc_host (
  input  wire        clock,
  input  wire        rst,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [7:0]  cmd_op,
  input  wire [23:0] cmd_addr,
  input  wire [15:0] cmd_len,
  input  wire        wr_valid,
  output wire        wr_ready,
  input  wire [7:0]  wr_data,
  output wire        rd_valid,
  input  wire        rd_ready,
  output wire [7:0]  rd_data,
  output wire        busy,
  output wire        done,
  output wire        cmd_err,
  output wire        sck,
  output wire        cs_n,
  output wire        io0_out,
  output wire        io0_oe,
  input  wire        io0_in,
  output wire        io1_out,
  output wire        io1_oe,
  input  wire        io1_in
);
  localparam [2:0] S_IDLE = 3'h0, S_START = 3'h1, S_LOAD = 3'h2, S_LOW = 3'h3, S_HIGH = 3'h4, S_GAP = 3'h5;
  localparam [2:0] P_OP = 3'h0, P_ADDR = 3'h1, P_DUMMY = 3'h2, P_WDATA = 3'h3, P_RDATA = 3'h4, P_END = 3'h5;
  localparam integer HALF_I  = `SFC_HALF_CYC;
  localparam integer GAP_I   = `SFC_CS_HIGH_CYC;
  localparam [3:0]   HALF    = HALF_I[3:0];
  localparam [4:0]   CS_HIGH = GAP_I[4:0];

  reg [2:0]  state_reg;
  reg [2:0]  phase_reg;
  reg [7:0]  op_reg;
  reg [23:0] addr_reg;
  reg [15:0] len_reg;
  reg        has_addr_reg;
  reg        dummy_reg;
  reg        dual_addr_reg;
  reg        dual_data_reg;
  reg        wdata_reg;
  reg        rdata_reg;
  reg        pre_reg;
  reg [1:0]  aidx_reg;
  reg [3:0]  bits_reg;
  reg [7:0]  sh_reg;
  reg [7:0]  rx_reg;
  reg [3:0]  div_reg;
  reg [4:0]  gap_reg;
  reg        sck_reg;
  reg        cs_n_reg;
  reg        io0_out_reg;
  reg        io1_out_reg;
  reg        io0_oe_reg;
  reg        io1_oe_reg;
  reg        push_reg;
  reg        done_reg;
  reg        err_reg;
  reg        io0_m_reg;
  reg        io0_s_reg;
  reg        io1_m_reg;
  reg        io1_s_reg;
  wire       buf_in_ready;
  wire       tick;
  wire       dual_now;
  wire       need_wel;
  wire       is_addr;
  wire       is_dummy;
  wire       is_rd;
  wire       is_wr;
  wire       bad;
  reg [2:0]  nxt;

  assign cmd_ready = (state_reg == S_IDLE);
  assign busy      = (state_reg != S_IDLE);
  assign wr_ready  = (state_reg == S_LOAD) && (phase_reg == P_WDATA);
  assign done      = done_reg;
  assign cmd_err   = err_reg;
  assign sck       = sck_reg;
  assign cs_n      = cs_n_reg;
  assign io0_out   = io0_out_reg;
  assign io1_out   = io1_out_reg;
  assign io0_oe    = io0_oe_reg;
  assign io1_oe    = io1_oe_reg;

  // ============================================================
  // command decode
  // write enable prefix
  assign need_wel = (cmd_op == `SFC_OP_SECTOR_ER_A) || (cmd_op == `SFC_OP_SECTOR_ER_B) ||
                    (cmd_op == `SFC_OP_BLOCK_ER) || (cmd_op == `SFC_OP_CHIP_ER_A) ||
                    (cmd_op == `SFC_OP_CHIP_ER_B) || (cmd_op == `SFC_OP_PAGE_PROG) ||
                    (cmd_op == `SFC_OP_STATUS_WRITE);
  assign is_addr  = (cmd_op == `SFC_OP_READ) || (cmd_op == `SFC_OP_FAST_READ) ||
                    (cmd_op == `SFC_OP_DUAL_OUT) || (cmd_op == `SFC_OP_DUAL_IO) ||
                    (cmd_op == `SFC_OP_SECTOR_ER_A) || (cmd_op == `SFC_OP_SECTOR_ER_B) ||
                    (cmd_op == `SFC_OP_BLOCK_ER) || (cmd_op == `SFC_OP_PAGE_PROG) ||
                    ((cmd_op == `SFC_OP_IDENT) && (cmd_len != 16'h0000));
  assign is_dummy = (cmd_op == `SFC_OP_FAST_READ) || (cmd_op == `SFC_OP_DUAL_OUT) ||
                    (cmd_op == `SFC_OP_DUAL_IO);
  assign is_rd    = (cmd_op == `SFC_OP_READ) || (cmd_op == `SFC_OP_FAST_READ) ||
                    (cmd_op == `SFC_OP_DUAL_OUT) || (cmd_op == `SFC_OP_DUAL_IO) ||
                    (cmd_op == `SFC_OP_STATUS_READ) || (cmd_op == `SFC_OP_JEDEC_ID) ||
                    ((cmd_op == `SFC_OP_IDENT) && (cmd_len != 16'h0000));
  assign is_wr    = (cmd_op == `SFC_OP_PAGE_PROG) || (cmd_op == `SFC_OP_STATUS_WRITE);
  assign bad      = ((cmd_op == `SFC_OP_PAGE_PROG) &&
                     ((cmd_len == 16'h0000) || (cmd_len > `SFC_PAGE_MAX))) ||
                    (is_rd && (cmd_len == 16'h0000));

  assign dual_now = (((phase_reg == P_ADDR) || (phase_reg == P_DUMMY)) && dual_addr_reg) ||
                    ((phase_reg == P_RDATA) && dual_data_reg);

  // ============================================================
  // sck divider
  // sck at most 25 MHz
  assign tick = (div_reg == HALF - 4'h1);

  // ============================================================
  // pin input synchronisers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      io0_m_reg <= 1'b0;
      io0_s_reg <= 1'b0;
      io1_m_reg <= 1'b0;
      io1_s_reg <= 1'b0;
    end else begin
      io0_m_reg <= io0_in;
      io0_s_reg <= io0_m_reg;
      io1_m_reg <= io1_in;
      io1_s_reg <= io1_m_reg;
    end
  end

  // ============================================================
  // phase after a finished byte
  always @* begin
    nxt = P_END;
    case (phase_reg)
      P_OP: begin
        if (pre_reg) begin
          nxt = P_END;
        end else if (has_addr_reg) begin
          nxt = P_ADDR;
        end else if (wdata_reg) begin
          nxt = P_WDATA;
        end else if (rdata_reg) begin
          nxt = P_RDATA;
        end
      end
      P_ADDR: begin
        if (aidx_reg != `SFC_ADDR_LAST) begin
          nxt = P_ADDR;
        end else if (dummy_reg) begin
          nxt = P_DUMMY;
        end else if (wdata_reg) begin
          nxt = P_WDATA;
        end else if (rdata_reg) begin
          nxt = P_RDATA;
        end
      end
      P_DUMMY: begin
        nxt = rdata_reg ? P_RDATA : P_END;
      end
      P_WDATA, P_RDATA: begin
        nxt = (len_reg == 16'h0001) ? P_END : phase_reg;
      end
      default: begin
        nxt = P_END;
      end
    endcase
  end

  // ============================================================
  // frame sequencer
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      phase_reg     <= P_OP;
      op_reg        <= 8'h00;
      addr_reg      <= 24'h000000;
      len_reg       <= 16'h0000;
      has_addr_reg  <= 1'b0;
      dummy_reg     <= 1'b0;
      dual_addr_reg <= 1'b0;
      dual_data_reg <= 1'b0;
      wdata_reg     <= 1'b0;
      rdata_reg     <= 1'b0;
      pre_reg       <= 1'b0;
      aidx_reg      <= 2'h0;
      bits_reg      <= 4'h0;
      sh_reg        <= 8'h00;
      rx_reg        <= 8'h00;
      div_reg       <= 4'h0;
      gap_reg       <= 5'h00;
      sck_reg       <= 1'b0;
      cs_n_reg      <= 1'b1;
      push_reg      <= 1'b0;
      done_reg      <= 1'b0;
      err_reg       <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
      div_reg  <= tick ? 4'h0 : div_reg + 4'h1;
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid && bad) begin
            err_reg <= 1'b1;
          end else if (cmd_valid) begin
            op_reg        <= cmd_op;
            if ((cmd_op == `SFC_OP_SECTOR_ER_A) || (cmd_op == `SFC_OP_SECTOR_ER_B)) begin
              addr_reg <= cmd_addr & `SFC_SECTOR_MASK;
            end else if (cmd_op == `SFC_OP_BLOCK_ER) begin
              addr_reg <= cmd_addr & `SFC_BLOCK_MASK;
            end else begin
              addr_reg <= cmd_addr;
            end
            len_reg       <= (cmd_op == `SFC_OP_STATUS_WRITE) ? 16'h0001 :
                             ((is_rd || is_wr) ? cmd_len : 16'h0000);
            has_addr_reg  <= is_addr;
            dummy_reg     <= is_dummy;
            dual_addr_reg <= (cmd_op == `SFC_OP_DUAL_IO);
            dual_data_reg <= (cmd_op == `SFC_OP_DUAL_IO) || (cmd_op == `SFC_OP_DUAL_OUT);
            wdata_reg     <= is_wr;
            rdata_reg     <= is_rd;
            pre_reg       <= need_wel;
            state_reg     <= S_START;
          end
        end
        S_START: begin
          cs_n_reg  <= 1'b0;
          phase_reg <= P_OP;
          aidx_reg  <= 2'h0;
          state_reg <= S_LOAD;
        end
        S_LOAD: begin
          div_reg <= 4'h0;
          bits_reg <= dual_now ? `SFC_DUAL_CLKS : `SFC_BYTE_CLKS;
          case (phase_reg)
            P_OP: begin
              sh_reg    <= pre_reg ? `SFC_OP_WRITE_EN : op_reg;
              state_reg <= S_LOW;
            end
            P_ADDR: begin
              sh_reg    <= (aidx_reg == 2'h0) ? addr_reg[23:16] :
                           ((aidx_reg == 2'h1) ? addr_reg[15:8] : addr_reg[7:0]);
              state_reg <= S_LOW;
            end
            P_WDATA: begin
              if (wr_valid) begin
                sh_reg    <= wr_data;
                state_reg <= S_LOW;
              end
            end
            P_RDATA: begin
              // a push still in flight must land before free space is judged
              if (buf_in_ready && !push_reg) begin
                sh_reg    <= 8'h00;
                state_reg <= S_LOW;
              end
            end
            default: begin
              sh_reg    <= 8'h00;
              state_reg <= S_LOW;
            end
          endcase
        end
        S_LOW: begin
          if (tick) begin
            sck_reg   <= 1'b1;
            state_reg <= S_HIGH;
            if (dual_now) begin
              rx_reg <= {rx_reg[5:0], io1_s_reg, io0_s_reg};
            end else begin
              rx_reg <= {rx_reg[6:0], io1_s_reg};
            end
          end
        end
        S_HIGH: begin
          if (tick) begin
            sck_reg  <= 1'b0;
            sh_reg   <= dual_now ? {sh_reg[5:0], 2'b00} : {sh_reg[6:0], 1'b0};
            bits_reg <= bits_reg - 4'h1;
            if (bits_reg == 4'h1) begin
              push_reg <= (phase_reg == P_RDATA);
              if ((phase_reg == P_WDATA) || (phase_reg == P_RDATA)) begin
                len_reg <= len_reg - 16'h0001;
              end
              if (phase_reg == P_ADDR) begin
                aidx_reg <= aidx_reg + 2'h1;
              end
              if (nxt == P_END) begin
                cs_n_reg  <= 1'b1;
                gap_reg   <= CS_HIGH;
                state_reg <= S_GAP;
              end else begin
                phase_reg <= nxt;
                state_reg <= S_LOAD;
              end
            end else begin
              state_reg <= S_LOW;
            end
          end
        end
        S_GAP: begin
          gap_reg <= gap_reg - 5'h01;
          if (gap_reg == 5'h01) begin
            if (pre_reg) begin
              pre_reg   <= 1'b0;
              state_reg <= S_START;
            end else begin
              done_reg  <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // pin drivers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      io0_out_reg <= 1'b0;
      io1_out_reg <= 1'b0;
      io0_oe_reg  <= 1'b0;
      io1_oe_reg  <= 1'b0;
    end else begin
      io0_out_reg <= dual_now ? sh_reg[6] : sh_reg[7];
      io1_out_reg <= dual_now ? sh_reg[7] : 1'b0;
      io0_oe_reg  <= !cs_n_reg && !((phase_reg == P_RDATA) && dual_data_reg) &&
                     !((phase_reg == P_DUMMY) && dual_data_reg);
      io1_oe_reg  <= !cs_n_reg && dual_addr_reg && (phase_reg == P_ADDR);
    end
  end

  // ============================================================
  // receive buffer
  sfc_buf #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push_reg),
    .in_ready  (buf_in_ready),
    .in_data   (rx_reg),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );
endmodule

//--- sfc_consts.vh
// Purpose: constants for the serial flash command controller
// Assumes: 250 MHz system clock
// Notes:   timing counts are rounded up to whole clock cycles
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// ============================================================
// opcodes
`define SFC_OP_READ         8'h03
`define SFC_OP_FAST_READ    8'h0B
`define SFC_OP_DUAL_OUT     8'h3B
`define SFC_OP_DUAL_IO      8'hBB
`define SFC_OP_SECTOR_ER_A  8'h20
`define SFC_OP_SECTOR_ER_B  8'hD7
`define SFC_OP_BLOCK_ER     8'hD8
`define SFC_OP_CHIP_ER_A    8'h60
`define SFC_OP_CHIP_ER_B    8'hC7
`define SFC_OP_PAGE_PROG    8'h02
`define SFC_OP_STATUS_READ  8'h05
`define SFC_OP_STATUS_WRITE 8'h01
`define SFC_OP_WRITE_EN     8'h06
`define SFC_OP_WRITE_DIS    8'h04
`define SFC_OP_IDENT        8'hAB
`define SFC_OP_JEDEC_ID     8'h9F
`define SFC_OP_DEEP_SLEEP   8'hB9

// ============================================================
// frame sizes
`define SFC_BYTE_CLKS       4'h8
`define SFC_DUAL_CLKS       4'h4
`define SFC_ADDR_LAST       2'h2
`define SFC_PAGE_MAX        16'h0100
`define SFC_SECTOR_MASK     24'hFFF000
`define SFC_BLOCK_MASK      24'hFF0000

// ============================================================
// timing
`define SFC_CLK_NS          4
`define SFC_SCK_MIN_PER_NS  40
`define SFC_HALF_CYC        ((`SFC_SCK_MIN_PER_NS / 2 + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_CS_HIGH_NS      50
`define SFC_CS_HIGH_CYC     ((`SFC_CS_HIGH_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)

`endif

//--- sfc_buf.v
// Purpose: two-entry valid/ready buffer for received bytes
// Assumes: single clock, asynchronous active-high reset
// Notes:   out_data comes from flip-flop storage
`timescale 1ns/1ps
module sfc_buf #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [0:0]       wr_ptr_reg;
  reg [0:0]       rd_ptr_reg;
  reg [1:0]       count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[1:0]);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ============================================================
  // storage
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          mem_reg[i] <= {WIDTH{1'b0}};
        end else if (push && (wr_ptr_reg == i)) begin
          mem_reg[i] <= in_data;
        end
      end
    end
  endgenerate

  // ============================================================
  // pointers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule

//--- sfc_checker.sv
// Purpose: port-level checks of the serial flash host
// Assumes: 250 MHz clock, mode 0 sck at 25 MHz
// Notes:   bound into every sfc_host instance
`timescale 1ns/1ps
module sfc_checker (
  input wire        clock,
  input wire        rst,
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [7:0]  cmd_op,
  input wire [15:0] cmd_len,
  input wire        rd_valid,
  input wire        rd_ready,
  input wire [7:0]  rd_data,
  input wire        busy,
  input wire        done,
  input wire        cmd_err,
  input wire        sck,
  input wire        cs_n,
  input wire        io0_out,
  input wire        io0_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire take  = cmd_valid && cmd_ready;
  wire rd_op = cmd_op == 8'h03 || cmd_op == 8'h0B || cmd_op == 8'h3B || cmd_op == 8'hBB;
  // ============================================================
  // link framing
  a_idle_sck: assert property (cs_n |-> !sck) else $error("sck high outside frame");
  a_frame_busy: assert property (!cs_n |-> busy) else $error("frame while idle");
  a_high_phase: assert property ($rose(sck) |=> sck[*4] ##1 !sck)
    else $error("sck high phase wrong");
  a_low_phase: assert property ($fell(sck) && !cs_n |=> (!sck)[*4])
    else $error("sck low phase short");
  a_out_settled: assert property ($rose(sck) |-> $stable(io0_out) && $stable(io0_oe))
    else $error("io0 moved at sck rise");
  a_cs_gap: assert property ($rose(cs_n) |=> cs_n[*8] ##1 cs_n[*4])
    else $error("chip select gap short");
  a_done_gap: assert property (done |-> cs_n && $past(cs_n, 12))
    else $error("done before gap");
  // ============================================================
  // command port
  a_done_ready: assert property (done |=> cmd_ready && !busy)
    else $error("not idle after done");
  a_prog_refuse: assert property (take && cmd_op == 8'h02 && (cmd_len == 16'h0000 || cmd_len > 16'h0100)
    |=> cmd_err && !busy) else $error("bad program length taken");
  a_read_refuse: assert property (take && rd_op && cmd_len == 16'h0000 |=> cmd_err && !busy)
    else $error("empty read taken");
  a_take_ok: assert property (take && (cmd_op == 8'h04 || cmd_op == 8'hB9)
    |=> busy && !cmd_err ##[1:2] !cs_n) else $error("frame did not start");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read byte dropped");
endmodule
bind sfc_host sfc_checker chk_u (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .busy(busy), .done(done), .cmd_err(cmd_err), .sck(sck), .cs_n(cs_n), .io0_out(io0_out), .io0_oe(io0_oe));

//--- sfc_flash_model.sv
// Purpose: behavioural serial flash on the host's far side
// Assumes: mode 0 frames, sck made by the host
// Notes:   array content is a fixed function of the address
`timescale 1ns/1ps
module sfc_flash_model #(
  parameter ID_CODE = 8'h5E  // arbitrary value
) (
  input  wire        sck,
  input  wire        cs_n,
  input  wire        wp_n,
  input  wire        si0,
  input  wire        si1,
  output reg         so0,
  output reg         so1,
  output reg  [63:0] rec
);
  reg  [7:0]  op, sr, dat, val;
  reg  [23:0] adr;
  reg  [15:0] n;
  reg         write_enable_latch, slp;
  integer     s, t, k;
  function [7:0] fmem(input [18:0] a);
    fmem = a[7:0] ^ {5'h00, a[18:16]} ^ 8'h3C;
  endfunction
  function prot(input [7:0] o, input [18:0] a);
    reg [18:0] sz;
    begin
      sz = 19'h08000 << sr[3:2];
      prot = (o == 8'h60 || o == 8'hC7) ? (sr[4:2] != 3'h0) :
             ((o == 8'h02 || o == 8'h20 || o == 8'hD7 || o == 8'hD8) &&
              (sr[4] || (sr[3:2] != 2'h0 && (sr[5] ? (a < sz) : (~a < sz)))));
    end
  endfunction
  initial {op, sr, dat, adr, n, write_enable_latch, slp, so0, so1, rec} = '0;
  // ============================================================
  // frame decode
  always @* begin
    case (op)
      8'h03, 8'hAB: s = 32;
      8'h0B, 8'h3B: s = 40;
      8'hBB:        s = 24;
      default:      s = 8;
    endcase
  end
  always @(negedge cs_n) begin
    n = 0;
    adr = 0;
    dat = 0;
  end
  always @(posedge sck) if (!cs_n) begin
    if (n < 8) op = {op[6:0], si0};
    else if (op == 8'hBB && n < 20) adr = {adr[21:0], si1, si0};
    else if (n < 32 && op != 8'hBB && op != 8'h01 && op != 8'h05) adr = {adr[22:0], si0};
    if (op == 8'h02 && n >= 32 || op == 8'h01 && n >= 8) dat = {dat[6:0], si0};
    n = n + 1;
  end
  always @(negedge sck) begin
    so0 = ~so0;
    so1 = ~so1;
    if (!cs_n && !slp && n >= s && (op == 8'h03 || op == 8'h0B || op == 8'h3B || op == 8'hBB
        || op == 8'hAB || op == 8'h05)) begin
      t = n - s;
      k = (op == 8'h3B || op == 8'hBB) ? t / 4 : t / 8;
      val = op == 8'h05 ? {sr[7:2], write_enable_latch, 1'b0} : op == 8'hAB ? ID_CODE : fmem(adr[18:0] + k[18:0]);
      if (op == 8'h3B || op == 8'hBB) begin
        so1 = val[7 - 2 * (t % 4)];
        so0 = val[6 - 2 * (t % 4)];
      end else so1 = val[7 - t % 8];
    end
  end
  always @(posedge cs_n) begin
    rec = {6'h00, prot(op, adr[18:0]), write_enable_latch, op, adr, n, dat};
    if (n[2:0] == 3'h0 && !slp) begin
      case (op)
        8'h06: write_enable_latch = 1'b1;
        8'h04, 8'h02, 8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7: write_enable_latch = 1'b0;
        8'h01: begin
          if (write_enable_latch && n == 16 && (wp_n || !sr[7])) sr = dat;
          write_enable_latch = 1'b0;
        end
        8'hB9: slp = 1'b1;
        default: ;
      endcase
    end
    if (op == 8'hAB && n == 8) slp = 1'b0;
  end
endmodule

//--- test_sfc_host.sv
// Purpose: self-checking bench for the serial flash host
// Assumes: 250 MHz clock, behavioural flash on the far side
// Notes:   read bytes and frame records checked from queues
`timescale 1ns/1ps
module test_sfc_host;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
  localparam  ID = 8'h5E;  // arbitrary value
  reg         clock, rst, cmd_valid, wr_valid, rd_ready, wp_n, wr_hs, stall;
  reg  [7:0]  cmd_op, wr_data;
  reg  [23:0] cmd_addr;
  reg  [15:0] cmd_len;
  wire        cmd_ready, wr_ready, rd_valid, busy, done, cmd_err;
  wire        sck, cs_n, io0_out, io0_oe, io1_out, io1_oe, so0, so1;
  wire [7:0]  rd_data;
  wire [63:0] rec;
  wire        io0_in = io0_oe ? io0_out : so0;
  wire        io1_in = io1_oe ? io1_out : so1;
  integer     n_fail = 0, checks = 0, seed = 87094, i;
  reg  [7:0]  rq[$];
  reg  [63:0] fq[$];
  reg  [7:0]  rop[4] = '{8'h03, 8'h0B, 8'h3B, 8'hBB};
  reg  [15:0] rbit[4] = '{16'h0038, 16'h0040, 16'h0034, 16'h0024};
  sfc_host dut_u (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy), .done(done), .cmd_err(cmd_err),
    .sck(sck), .cs_n(cs_n), .io0_out(io0_out), .io0_oe(io0_oe), .io0_in(io0_in), .io1_out(io1_out),
    .io1_oe(io1_oe), .io1_in(io1_in));
  sfc_flash_model #(.ID_CODE(ID)) fm_u (.sck(sck), .cs_n(cs_n), .wp_n(wp_n), .si0(io0_in), .si1(io1_in),
    .so0(so0), .so1(so1), .rec(rec));
  function [7:0] fmem(input [18:0] a);
    fmem = a[7:0] ^ {5'h00, a[18:16]} ^ 8'h3C;
  endfunction
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ============================================================
  // data streams and result checking
  always @(negedge clock) rd_ready <= !stall && ($random(seed) & 3) != 0;
  always @(posedge clock) wr_hs <= wr_valid && wr_ready;
  always @(negedge clock) if (wr_hs) wr_data <= wr_data + 8'h01;
  always @(posedge clock) begin
    if (rd_valid && rd_ready) begin
      if (rq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(rd_data, rq.pop_front())
    end
    if (done && fq.size() != 0) `CHK(rec, fq.pop_front())
  end
  task close_out;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task automatic run(input [7:0] op, input [23:0] a, input [15:0] len, input [7:0] wd, input ok);
    integer w;
    begin
      @(negedge clock);
      cmd_op = op;
      cmd_addr = a;
      cmd_len = len;
      wr_data = wd;
      cmd_valid = 1'b1;
      @(posedge clock);
      while (!cmd_ready) @(posedge clock);
      @(negedge clock);
      cmd_valid = 1'b0;
      w = 0;
      while (!done && !cmd_err && w < 60000) begin
        @(negedge clock);
        w++;
      end
      `CHK({done, cmd_err}, {ok, !ok})
      $display("test op %h end", op);
    end
  endtask
  task automatic frm(input [7:0] op, input [23:0] a, input [15:0] len, input [7:0] wd,
                     input [15:0] bits, input [23:0] ea, input [7:0] lb, input [1:0] write_enable_latch);
    begin
      fq.push_back({6'h00, write_enable_latch, op, ea, bits, lb});
      run(op, a, len, wd, 1'b1);
    end
  endtask
  task automatic rd(input [7:0] op, input [23:0] a, input [15:0] len, input [15:0] bits, input [7:0] st);
    integer k;
    begin
      for (k = 0; k < len; k++) rq.push_back(op == 8'h05 ? st : op == 8'hAB ? ID : fmem(a[18:0] + k[18:0]));
      frm(op, a, len, 8'h00, bits, a, 8'h00, 1'b0);
    end
  endtask
  // ============================================================
  // main sequence
  initial begin
    {cmd_valid, cmd_op, cmd_addr, cmd_len, wr_data, wr_hs, stall, rd_ready} = '0;
    rst = 1'b1;
    wr_valid = 1'b1;
    wp_n = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    `CHK({cs_n, sck, cmd_ready, busy, io0_oe}, 5'h14)
    for (i = 0; i < 4; i++) rd(rop[i], 24'h07FFFE, 16'h0003, rbit[i], 8'h00);
    stall = 1'b1;
    fork
      rd(8'h03, 24'h000010, 16'h0004, 16'h0040, 8'h00);
      begin
        repeat (900) @(negedge clock);
        `CHK(rd_valid, 1'b1)
        stall = 1'b0;
      end
    join
    frm(8'h20, 24'h012345, 16'h0000, 8'h00, 16'h0020, 24'h012000, 8'h00, 1'b1);
    frm(8'hD7, 24'h0ABCDE, 16'h0000, 8'h00, 16'h0020, 24'h0AB000, 8'h00, 1'b1);
    frm(8'hD8, 24'h054321, 16'h0000, 8'h00, 16'h0020, 24'h050000, 8'h00, 1'b1);
    frm(8'h60, 24'h012345, 16'h0000, 8'h00, 16'h0008, 24'h000000, 8'h00, 1'b1);
    frm(8'hC7, 24'h012345, 16'h0000, 8'h00, 16'h0008, 24'h000000, 8'h00, 1'b1);
    frm(8'h02, 24'h000100, 16'h0100, 8'hC0, 16'h0820, 24'h000100, 8'hBF, 1'b1);
    frm(8'h04, 24'h000000, 16'h0000, 8'h00, 16'h0008, 24'h000000, 8'h00, 1'b0);
    frm(8'hB9, 24'h000000, 16'h0000, 8'h00, 16'h0008, 24'h000000, 8'h00, 1'b0);
    frm(8'hAB, 24'h000000, 16'h0000, 8'h00, 16'h0008, 24'h000000, 8'h00, 1'b0);
    frm(8'h01, 24'h000000, 16'h0000, 8'h9C, 16'h0010, 24'h000000, 8'h9C, 1'b1);
    wp_n = 1'b0;
    frm(8'h01, 24'h000000, 16'h0000, 8'h00, 16'h0010, 24'h000000, 8'h00, 1'b1);
    rd(8'h05, 24'h000000, 16'h0002, 16'h0018, 8'h9C);
    wp_n = 1'b1;
    frm(8'h01, 24'h000000, 16'h0000, 8'h00, 16'h0010, 24'h000000, 8'h00, 1'b1);
    rd(8'h05, 24'h000000, 16'h0002, 16'h0018, 8'h00);
    rd(8'hAB, 24'h123456, 16'h0002, 16'h0030, 8'h00);
    frm(8'h01, 24'h000000, 16'h0000, 8'h04, 16'h0010, 24'h000000, 8'h04, 2'h1);
    frm(8'h20, 24'h07F123, 16'h0000, 8'h00, 16'h0020, 24'h07F000, 8'h00, 2'h3);
    frm(8'h20, 24'h06F000, 16'h0000, 8'h00, 16'h0020, 24'h06F000, 8'h00, 2'h1);
    frm(8'h01, 24'h000000, 16'h0000, 8'h2C, 16'h0010, 24'h000000, 8'h2C, 2'h1);
    frm(8'hD8, 24'h03ABCD, 16'h0000, 8'h00, 16'h0020, 24'h030000, 8'h00, 2'h3);
    frm(8'hD8, 24'h041234, 16'h0000, 8'h00, 16'h0020, 24'h040000, 8'h00, 2'h1);
    frm(8'h01, 24'h000000, 16'h0000, 8'h30, 16'h0010, 24'h000000, 8'h30, 2'h1);
    frm(8'h20, 24'h07F000, 16'h0000, 8'h00, 16'h0020, 24'h07F000, 8'h00, 2'h3);
    frm(8'h01, 24'h000000, 16'h0000, 8'h20, 16'h0010, 24'h000000, 8'h20, 2'h1);
    frm(8'h20, 24'h000ABC, 16'h0000, 8'h00, 16'h0020, 24'h000000, 8'h00, 2'h1);
    run(8'h02, 24'h000000, 16'h0000, 8'h00, 1'b0);
    run(8'h02, 24'h000000, 16'h0101, 8'h00, 1'b0);
    run(8'h03, 24'h000000, 16'h0000, 8'h00, 1'b0);
    repeat (20) @(negedge clock);
    close_out;
  end
  initial begin
    #300000;
    n_fail++;
    close_out;
  end
endmodule
